// ---- dv/acl_analog_model.sv ----
// Behavioural analog multiplexer and comparator facing the converter
`timescale 1ns/10ps
module acl_analog_model (
  input wire logic pclk,
  input wire logic sample_en,
  input wire logic [9:0] dac_code,
  input wire logic [4:0] channel_out,
  input wire logic [9:0] vin,
  output logic comp_in
);
  logic [9:0] held = 10'h000;
  logic noise = 1'b0;

  // Input is tracked onto the hold capacitor only while the window is open, and held once it closes
  always @(posedge pclk)
  begin
    noise <= ~noise;
    if (sample_en)
      held <= vin;
  end

  // Channel off: the comparator sees nothing useful, so give it churn
  assign comp_in = (channel_out == 5'h1f) ? noise : (held >= dac_code);
endmodule : acl_analog_model

// ---- dv/acl_ctrl_tb.sv ----
// Self-checking bench of the converter control top
`timescale 1ns/10ps
module acl_ctrl_tb;
  typedef struct {
    logic [9:0] vin;
    logic [7:0] cfg;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] smp;
  } acl_row_type;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic cpu_stop = 1'b0;
  logic hw_trigger = 1'b0;
  logic [9:0] vin = 10'h000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic comp_in;
  logic [9:0] dac_code;
  logic sample_en;
  logic [4:0] channel_out;
  logic conv_active;
  logic conv_irq;
  logic irq;
  logic [31:0] rd;
  logic er;
  int smp;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Rows: input level, clock_cfg, result high, result low, sample cycles
  acl_row_type rows[6] = '{
    '{10'h3ff, 8'h02, 32'h3, 32'hff, 32'd7},
    '{10'h000, 8'h03, 32'h0, 32'h00, 32'd47},
    '{10'h2a5, 8'h02, 32'h2, 32'ha5, 32'd7},
    '{10'h2a6, 8'h00, 32'h0, 32'haa, 32'd7},
    '{10'h3fe, 8'h01, 32'h0, 32'hff, 32'd47},
    '{10'h002, 8'h00, 32'h0, 32'h01, 32'd7}
  };

  acl_ctrl uut (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cpu_stop(cpu_stop),
    .hw_trigger(hw_trigger),
    .comp_in(comp_in),
    .dac_code(dac_code),
    .sample_en(sample_en),
    .channel_out(channel_out),
    .conv_active(conv_active),
    .conv_irq(conv_irq),
    .irq(irq)
  );

  acl_analog_model model (
    .pclk(pclk),
    .sample_en(sample_en),
    .dac_code(dac_code),
    .channel_out(channel_out),
    .vin(vin),
    .comp_in(comp_in)
  );

  initial
  begin
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  // One APB transfer; the extra trailing edge lets the access edge settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; pready !== 1'b1 && n < 100; n++)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdx(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
  endtask : rdx

  // Counts cycles with the sample window open until the converter idles
  task automatic run_conv(output int s);
    int n;
    s = 0;
    for (n = 0; conv_active !== 1'b1 && n < 100; n++)
      @(posedge pclk);
    for (n = 0; conv_active === 1'b1 && n < 400; n++)
    begin
      if (sample_en === 1'b1)
        s++;
      @(posedge pclk);
    end
    chk("conv_bounded", 32'h1, 32'(n < 400));
  endtask : run_conv

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("channel_reset", 32'h1f, 32'(channel_out));
    rdx(acl_pkg::ADDR_CTRL_STATUS, 32'h1f, "ctrl_reset");
    rdx(acl_pkg::ADDR_RESULT_LOW, 32'h0, "low_reset");
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk("unmapped_err", 32'h1, 32'(er));
    chk("unmapped_data", 32'h0, rd);
    foreach (rows[i])
    begin
      vin <= rows[i].vin;
      wr(acl_pkg::ADDR_CLOCK_CFG, {24'h0, rows[i].cfg});
      wr(acl_pkg::ADDR_CTRL_STATUS, 32'h43);
      run_conv(smp);
      chk("sample_len", rows[i].smp, 32'(smp));
      rdx(acl_pkg::ADDR_CTRL_STATUS, 32'hc3, "done_set");
      chk("irq_done", 32'h1, 32'(conv_irq));
      rdx(acl_pkg::ADDR_RESULT_HIGH, rows[i].hi, "res_high");
      rdx(acl_pkg::ADDR_RESULT_LOW, rows[i].lo, "res_low");
      chk("irq_by_read", 32'h0, 32'(conv_irq));
      rdx(acl_pkg::ADDR_CTRL_STATUS, 32'h43, "done_by_read");
      chk("single_idle", 32'h0, 32'(conv_active));
    end
    chk("channel_sel", 32'h03, 32'(channel_out));
    // Done flag without enable; event status masking and clearing
    vin <= 10'h0f0;
    wr(acl_pkg::ADDR_CLOCK_CFG, 32'h02);
    wr(acl_pkg::ADDR_EVT_STATUS, 32'h3);
    wr(acl_pkg::ADDR_EVT_MASK, 32'h0);
    wr(acl_pkg::ADDR_CTRL_STATUS, 32'h03);
    run_conv(smp);
    rdx(acl_pkg::ADDR_CTRL_STATUS, 32'h83, "done_no_ie");
    chk("irq_no_ie", 32'h0, 32'(conv_irq));
    chk("irq_masked", 32'h0, 32'(irq));
    rdx(acl_pkg::ADDR_EVT_STATUS, 32'h1, "evt_done");
    wr(acl_pkg::ADDR_EVT_MASK, 32'h1);
    chk("irq_unmasked", 32'h1, 32'(irq));
    wr(acl_pkg::ADDR_EVT_STATUS, 32'h1);
    chk("irq_cleared", 32'h0, 32'(irq));
    // Continuous mode re-arms by itself after each completion
    wr(acl_pkg::ADDR_CTRL_STATUS, 32'h23);
    run_conv(smp);
    repeat (2) @(posedge pclk);
    chk("cont_rearm", 32'h1, 32'(conv_active));
    // Stop without async clock in mid conversion, trigger mode so the lock matters
    vin <= 10'h155;
    wr(acl_pkg::ADDR_CLOCK_CFG, 32'h0a);
    wr(acl_pkg::ADDR_EVT_STATUS, 32'h3);
    wr(acl_pkg::ADDR_CTRL_STATUS, 32'h23);
    hw_trigger <= 1'b1;
    repeat (10) @(posedge pclk);
    cpu_stop <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("stop_abort", 32'h0, 32'(conv_active));
    rdx(acl_pkg::ADDR_EVT_STATUS, 32'h2, "evt_abort");
    rdx(acl_pkg::ADDR_RESULT_HIGH, 32'h0, "keep_high");
    rdx(acl_pkg::ADDR_RESULT_LOW, 32'hf0, "keep_low");
    cpu_stop <= 1'b0;
    hw_trigger <= 1'b0;
    @(posedge pclk);
    hw_trigger <= 1'b1;
    repeat (60) @(posedge pclk);
    chk("stop_lock", 32'h0, 32'(conv_active));
    hw_trigger <= 1'b0;
    wr(acl_pkg::ADDR_CLOCK_CFG, 32'h02);
    wr(acl_pkg::ADDR_CTRL_STATUS, 32'h43);
    run_conv(smp);
    rdx(acl_pkg::ADDR_RESULT_HIGH, 32'h1, "resume_high");
    chk("resume_irq", 32'h1, 32'(conv_irq));
    wr(acl_pkg::ADDR_CTRL_STATUS, 32'h5f);
    chk("irq_by_write", 32'h0, 32'(conv_irq));
    rdx(acl_pkg::ADDR_CTRL_STATUS, 32'h5f, "done_by_write");
    rdx(acl_pkg::ADDR_RESULT_LOW, 32'h55, "resume_low");
    // Stop with async clock: single mode so the wake is deliberate
    vin <= 10'h2aa;
    wr(acl_pkg::ADDR_CLOCK_CFG, 32'h06);
    wr(acl_pkg::ADDR_CTRL_STATUS, 32'h43);
    repeat (5) @(posedge pclk);
    cpu_stop <= 1'b1;
    run_conv(smp);
    rdx(acl_pkg::ADDR_RESULT_HIGH, 32'h2, "async_high");
    chk("async_irq", 32'h1, 32'(conv_irq));
    rdx(acl_pkg::ADDR_RESULT_LOW, 32'haa, "async_low");
    // Trigger mode while stopped waits for the trigger edge
    vin <= 10'h0cc;
    wr(acl_pkg::ADDR_CLOCK_CFG, 32'h0e);
    wr(acl_pkg::ADDR_CTRL_STATUS, 32'h43);
    repeat (20) @(posedge pclk);
    chk("trig_idle", 32'h0, 32'(conv_active));
    hw_trigger <= 1'b1;
    run_conv(smp);
    rdx(acl_pkg::ADDR_RESULT_HIGH, 32'h0, "trig_high");
    chk("trig_irq", 32'h1, 32'(conv_irq));
    rdx(acl_pkg::ADDR_RESULT_LOW, 32'hcc, "trig_low");
    hw_trigger <= 1'b0;
    cpu_stop <= 1'b0;
    // Reset mid-conversion must clear results that an abort would keep
    @(posedge pclk);
    hw_trigger <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("busy_before_rst", 32'h1, 32'(conv_active));
    presetn <= 1'b0;
    hw_trigger <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("active_rst2", 32'h0, 32'(conv_active));
    rdx(acl_pkg::ADDR_RESULT_LOW, 32'h0, "low_rst2");
    finish_test();
  end
endmodule : acl_ctrl_tb

// ---- hw/acl_clk_div.sv ----
// Conversion clock divider producing half-period ticks
`timescale 1ns/10ps
module acl_clk_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [1:0] div_sel,
  output logic half_tick
);
  logic [2:0] count;
  logic [2:0] limit;

  assign limit = 3'((4'h1 << div_sel) - 4'h1);
  assign half_tick = run && (count == limit);

  // Held at zero while idle so the first window starts aligned
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 3'h0;
    else if (!run || half_tick)
      count <= 3'h0;
    else
      count <= count + 3'h1;
  end
endmodule : acl_clk_div

// ---- hw/acl_ctrl.sv ----
// Converter control top: APB registers, start and abort control, standby handling
// Behaviour
// - Sample window 3.5 cycles, 23.5 when long
// - 1024 steps, rounded to 8 or 10 bits
// - Interrupt raised with done flag when enabled
// - Done flag set at every conversion end
// - Wait mode: conversions and interrupt continue
// - Single conversion returns to low power
// - Stop without async clock aborts conversion
// - After such stop, only control write restarts
// - Results keep last completed value after abort
// - Stop with async clock runs normally
// - Stop with trigger mode waits for trigger
// - Control write or low read clears done
// - Low read or control write withdraws interrupt
// - Abort leaves results; reset clears them
`timescale 1ns/10ps
module acl_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_stop,
  input wire logic hw_trigger,
  input wire logic comp_in,
  output logic [9:0] dac_code,
  output logic sample_en,
  output logic [4:0] channel_out,
  output logic conv_active,
  output logic conv_irq,
  output logic irq
);
  logic conv_done_flag;
  logic irq_enable;
  logic continuous_sel;
  logic [4:0] channel_select;
  logic long_sample_sel;
  logic res_10bit;
  logic async_clk_enable;
  logic ext_trigger_select;
  logic [1:0] clk_div;
  logic [9:0] result_high;
  logic [7:0] result_low;
  logic [acl_pkg::EVT_WIDTH-1:0] evt_status;
  logic [acl_pkg::EVT_WIDTH-1:0] evt_mask;
  logic stop_lock;
  logic stop_prev;
  logic trig_prev;
  logic cont_pending;
  logic access;
  logic mapped;
  logic ctrl_wr;
  logic cfg_wr;
  logic low_rd;
  logic stop_entry;
  logic stop_abort;
  logic trig_rise;
  logic sw_start;
  logic hw_start;
  logic core_start;
  logic core_abort;
  logic half_tick;
  logic sar_done;
  logic [9:0] sar_result;
  logic [31:0] next_prdata;
  logic [acl_pkg::EVT_WIDTH-1:0] evt_set;

  assign access = psel && penable;
  assign pready = 1'b1;
  assign mapped = paddr == acl_pkg::ADDR_CTRL_STATUS || paddr == acl_pkg::ADDR_RESULT_HIGH ||
                  paddr == acl_pkg::ADDR_RESULT_LOW || paddr == acl_pkg::ADDR_CLOCK_CFG ||
                  paddr == acl_pkg::ADDR_EVT_STATUS || paddr == acl_pkg::ADDR_EVT_MASK;
  assign pslverr = access && !mapped;
  assign ctrl_wr = access && pwrite && paddr == acl_pkg::ADDR_CTRL_STATUS;
  assign cfg_wr = access && pwrite && paddr == acl_pkg::ADDR_CLOCK_CFG;
  assign low_rd = access && !pwrite && paddr == acl_pkg::ADDR_RESULT_LOW;

  assign stop_entry = cpu_stop && !stop_prev;
  assign stop_abort = stop_entry && !async_clk_enable;
  assign trig_rise = hw_trigger && !trig_prev;

  // A control write restarts unless trigger mode waits for the pin or the written channel is off
  assign sw_start = ctrl_wr && !ext_trigger_select &&
                    acl_pkg::chan_ok(pwdata[acl_pkg::CS_CHAN_LSB+:5]);
  assign hw_start = trig_rise && ext_trigger_select && !stop_lock && !conv_active &&
                    acl_pkg::chan_ok(channel_select);
  // with the async clock on, stop takes no part in start or abort
  assign core_start = (sw_start || hw_start || cont_pending) && !stop_abort && !cfg_wr;
  assign core_abort = ctrl_wr || cfg_wr || stop_abort;

  assign channel_out = channel_select;
  assign conv_irq = conv_done_flag && irq_enable;
  assign irq = |(evt_status & evt_mask);

  acl_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(conv_active),
    .div_sel(async_clk_enable ? acl_pkg::ASYNC_DIV : clk_div),
    .half_tick(half_tick)
  );

  acl_sar_core u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .start(core_start),
    .abort(core_abort),
    .half_tick(half_tick),
    .long_sample(long_sample_sel),
    .comp_in(comp_in),
    .busy(conv_active),
    .sample_en(sample_en),
    .dac_code(dac_code),
    .done(sar_done),
    .result(sar_result)
  );

  // Control fields; the write itself is the abort and restart source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_enable <= 1'b0;
      continuous_sel <= 1'b0;
      channel_select <= acl_pkg::CHAN_RESET;
    end
    else if (ctrl_wr)
    begin
      irq_enable <= pwdata[acl_pkg::CS_IRQ_EN];
      continuous_sel <= pwdata[acl_pkg::CS_CONT];
      channel_select <= pwdata[acl_pkg::CS_CHAN_LSB+:5];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      long_sample_sel <= acl_pkg::CFG_RESET[acl_pkg::CFG_LONG];
      res_10bit <= acl_pkg::CFG_RESET[acl_pkg::CFG_RES10];
      async_clk_enable <= acl_pkg::CFG_RESET[acl_pkg::CFG_ASYNC];
      ext_trigger_select <= acl_pkg::CFG_RESET[acl_pkg::CFG_EXT];
      clk_div <= acl_pkg::CFG_RESET[acl_pkg::CFG_DIV_LSB+:2];
    end
    else if (cfg_wr)
    begin
      long_sample_sel <= pwdata[acl_pkg::CFG_LONG];
      res_10bit <= pwdata[acl_pkg::CFG_RES10];
      async_clk_enable <= pwdata[acl_pkg::CFG_ASYNC];
      ext_trigger_select <= pwdata[acl_pkg::CFG_EXT];
      clk_div <= pwdata[acl_pkg::CFG_DIV_LSB+:2];
    end
  end

  // Completion wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_done_flag <= 1'b0;
    else if (sar_done)
      conv_done_flag <= 1'b1;
    else if (ctrl_wr || low_rd)
      conv_done_flag <= 1'b0;
  end

  // Results change only on completion, never on abort
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_high <= 10'h000;
      result_low <= 8'h00;
    end
    else if (sar_done)
    begin
      result_high <= res_10bit ? {8'h00, sar_result[9:8]} : 10'h000;
      result_low <= res_10bit ? sar_result[7:0] : acl_pkg::round8(sar_result);
    end
  end

  // Stop without the async clock locks out every start but a control write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stop_lock <= 1'b0;
    else if (stop_abort)
      stop_lock <= 1'b1;
    else if (ctrl_wr)
      stop_lock <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_prev <= 1'b0;
      trig_prev <= 1'b0;
    end
    else
    begin
      stop_prev <= cpu_stop;
      trig_prev <= hw_trigger;
    end
  end

  // Continuous mode re-arms one cycle after completion; single mode idles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cont_pending <= 1'b0;
    else if (core_abort)
      cont_pending <= 1'b0;
    else
      cont_pending <= sar_done && continuous_sel && !stop_lock &&
                      acl_pkg::chan_ok(channel_select);
  end

  always_comb
  begin
    evt_set = '0;
    evt_set[acl_pkg::EVT_DONE] = sar_done;
    evt_set[acl_pkg::EVT_ABORT] = core_abort && conv_active && !core_start;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_status <= '0;
    else if (access && pwrite && paddr == acl_pkg::ADDR_EVT_STATUS)
      evt_status <= (evt_status & ~pwdata[acl_pkg::EVT_WIDTH-1:0]) | evt_set;
    else
      evt_status <= evt_status | evt_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_mask <= '0;
    else if (access && pwrite && paddr == acl_pkg::ADDR_EVT_MASK)
      evt_mask <= pwdata[acl_pkg::EVT_WIDTH-1:0];
  end

  // Read data is caught in the setup cycle so it comes from a flop
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      acl_pkg::ADDR_CTRL_STATUS:
        next_prdata[7:0] = {conv_done_flag, irq_enable, continuous_sel, channel_select};
      acl_pkg::ADDR_RESULT_HIGH:
        next_prdata[9:0] = result_high;
      acl_pkg::ADDR_RESULT_LOW:
        next_prdata[7:0] = result_low;
      acl_pkg::ADDR_CLOCK_CFG:
        next_prdata[5:0] = {clk_div, ext_trigger_select, async_clk_enable, res_10bit,
                            long_sample_sel};
      acl_pkg::ADDR_EVT_STATUS:
        next_prdata[acl_pkg::EVT_WIDTH-1:0] = evt_status;
      acl_pkg::ADDR_EVT_MASK:
        next_prdata[acl_pkg::EVT_WIDTH-1:0] = evt_mask;
      default:
        next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= next_prdata;
  end

  // Helper: half ticks counted across one sample window
  logic [5:0] win_count;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      win_count <= 6'h00;
    else if (!sample_en || core_start)
      win_count <= 6'h00;
    else if (half_tick)
      win_count <= win_count + 6'h01;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sample_len_a: assert property ($fell(sample_en) && !$past(core_abort) |->
    win_count == (long_sample_sel ? acl_pkg::SAMPLE_LONG_HALF : acl_pkg::SAMPLE_SHORT_HALF))
    else $error("sample window length wrong");

  round_result_a: assert property (sar_done && !res_10bit && !cfg_wr |=>
    result_low == acl_pkg::round8($past(sar_result)) && result_high == 10'h000)
    else $error("8-bit rounding wrong");

  irq_with_done_a: assert property (sar_done && irq_enable && !ctrl_wr |=> conv_irq)
    else $error("interrupt not raised on completion");

  done_flag_set_a: assert property (sar_done |=> conv_done_flag)
    else $error("done flag not set");

  single_idle_a: assert property (sar_done && !continuous_sel && !core_start |=>
    !conv_active [*2])
    else $error("single conversion did not idle");

  stop_abort_a: assert property (stop_entry && !async_clk_enable |=> !conv_active)
    else $error("stop did not abort");

  stop_lock_a: assert property (stop_lock && !ctrl_wr |-> !core_start)
    else $error("start while stop lock held");

  result_hold_a: assert property (!sar_done |=> $stable(result_low) &&
    $stable(result_high))
    else $error("result changed without completion");

  async_stop_runs_a: assert property (conv_active && cpu_stop && async_clk_enable &&
    !ctrl_wr && !cfg_wr && !sar_done |=> conv_active || sar_done)
    else $error("conversion lost in stop");

  trig_start_a: assert property (hw_start && !cfg_wr && !stop_abort |=> sample_en)
    else $error("trigger did not start conversion");

  done_clear_a: assert property ((ctrl_wr || low_rd) && !sar_done |=>
    !conv_done_flag && !conv_irq)
    else $error("done flag not cleared");

  irq_level_a: assert property ($changed(conv_irq) |->
    $past(sar_done) || $past(ctrl_wr) || $past(low_rd))
    else $error("interrupt level moved without done or clear");

  cont_chain_c: cover property (sar_done && continuous_sel ##2 sample_en);
  stop_abort_c: cover property (conv_active && stop_abort);
  trig_conv_c: cover property (hw_start && cpu_stop ##[1:1000] sar_done);
  long_win_c: cover property ($fell(sample_en) && long_sample_sel);

endmodule : acl_ctrl

// ---- hw/acl_pkg.sv ----
// Shared constants, types and helpers of the converter control block
package acl_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h08;
  localparam logic [7:0] ADDR_CLOCK_CFG = 8'h0c;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h14;

  // ctrl_status_reg fields
  localparam int CS_DONE = 7;
  localparam int CS_IRQ_EN = 6;
  localparam int CS_CONT = 5;
  localparam int CS_CHAN_LSB = 0;
  localparam logic [4:0] CHAN_RESET = 5'h1f;
  localparam logic [4:0] CHAN_OFF = 5'h1f;

  // Clock and mode configuration fields
  localparam int CFG_LONG = 0;
  localparam int CFG_RES10 = 1;
  localparam int CFG_ASYNC = 2;
  localparam int CFG_EXT = 3;
  localparam int CFG_DIV_LSB = 4;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Event status and mask bits
  localparam int EVT_DONE = 0;
  localparam int EVT_ABORT = 1;
  localparam int EVT_WIDTH = 2;

  // Sample window in half conversion-clock periods: 3.5 and 23.5 cycles
  localparam logic [5:0] SAMPLE_SHORT_HALF = 6'h07;
  localparam logic [5:0] SAMPLE_LONG_HALF = 6'h2f;
  // Divider setting standing in for the dedicated asynchronous clock
  localparam logic [1:0] ASYNC_DIV = 2'h1;
  localparam logic [9:0] SAR_MSB = 10'h200;
  localparam logic [3:0] SAR_LAST_BIT = 4'h9;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_TRIAL = 2'b10,
    PH_DECIDE = 2'b11
  } acl_phase_type;

  // Round a 10-bit outcome to 8 bits, saturating at full scale
  function automatic logic [7:0] round8(input logic [9:0] raw);
    if (raw[9:2] == 8'hff)
    begin
      return 8'hff;
    end
    return raw[9:2] + {7'h00, raw[1]};
  endfunction : round8

  function automatic logic chan_ok(input logic [4:0] chan);
    return chan != CHAN_OFF;
  endfunction : chan_ok

endpackage : acl_pkg

// ---- hw/acl_sar_core.sv ----
// Successive approximation sequencer: sample window then ten bit trials
`timescale 1ns/10ps
module acl_sar_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic abort,
  input wire logic half_tick,
  input wire logic long_sample,
  input wire logic comp_in,
  output logic busy,
  output logic sample_en,
  output logic [9:0] dac_code,
  output logic done,
  output logic [9:0] result
);
  acl_pkg::acl_phase_type phase;
  logic [5:0] count;
  logic [3:0] bit_idx;
  logic [9:0] kept;

  assign busy = phase != acl_pkg::PH_IDLE;
  assign sample_en = phase == acl_pkg::PH_SAMPLE;
  assign kept = comp_in ? dac_code : (dac_code & ~(10'h001 << bit_idx));

  // A start restarts even a running conversion; abort alone drops to idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= acl_pkg::PH_IDLE;
      count <= 6'h00;
      bit_idx <= 4'h0;
      dac_code <= 10'h000;
      done <= 1'b0;
      result <= 10'h000;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        phase <= acl_pkg::PH_SAMPLE;
        count <= 6'h00;
        dac_code <= 10'h000;
      end
      else if (abort)
        phase <= acl_pkg::PH_IDLE;
      else if (half_tick)
      begin
        case (phase)
          acl_pkg::PH_SAMPLE:
          begin
            if (count == (long_sample ? acl_pkg::SAMPLE_LONG_HALF : acl_pkg::SAMPLE_SHORT_HALF)
                - 6'h01)
            begin
              phase <= acl_pkg::PH_TRIAL;
              bit_idx <= acl_pkg::SAR_LAST_BIT;
              dac_code <= acl_pkg::SAR_MSB;
            end
            count <= count + 6'h01;
          end
          acl_pkg::PH_TRIAL:
            phase <= acl_pkg::PH_DECIDE;
          acl_pkg::PH_DECIDE:
          begin
            dac_code <= kept;
            if (bit_idx == 4'h0)
            begin
              phase <= acl_pkg::PH_IDLE;
              result <= kept;
              done <= 1'b1;
            end
            else
            begin
              phase <= acl_pkg::PH_TRIAL;
              bit_idx <= bit_idx - 4'h1;
              dac_code <= kept | (10'h001 << (bit_idx - 4'h1));
            end
          end
          default:
            phase <= acl_pkg::PH_IDLE;
        endcase
      end
    end
  end
endmodule : acl_sar_core
